/* rtl/gpa_arbiter.sv */
// Arbiter end: grants the bus and keeps the start window before re-granting
module gpa_arbiter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Link
    gpa_link_if.arbiter link,
    // User side
    input wire logic grant_en,
    input wire logic withdraw,
    output logic window_open,
    output logic started
);
    import gpa_pkg::*;

    typedef enum logic [1:0] {A_IDLE, A_GRANT, A_HOLD, A_BUSY} gpa_astate_type;
    typedef struct packed {
        gpa_astate_type st;
        logic gnt_n;
        logic [2:0] stat;
        logic [1:0] win;
        logic open;
        logic started;
    } gpa_areg_type;

    gpa_areg_type s_r, s_nxt;
    logic begun;

    assign begun = !link.frame_n || !link.pipe_n;

    always_comb begin
        s_nxt = s_r;
        s_nxt.started = 1'b0;
        unique case (s_r.st)
            A_IDLE: begin
                if (grant_en && !link.req_n && !withdraw) begin
                    s_nxt.gnt_n = 1'b0;
                    s_nxt.stat = GPA_ST_START;
                    s_nxt.st = A_GRANT;
                end
            end
            A_GRANT: begin
                s_nxt.win = 2'(GPA_PIPE_WIN);
                if (begun) begin
                    s_nxt.started = 1'b1;
                    s_nxt.gnt_n = 1'b1;
                    s_nxt.stat = GPA_ST_IDLE;
                    s_nxt.st = A_BUSY;
                end else if (withdraw || link.req_n) begin
                    s_nxt.gnt_n = 1'b1;
                    s_nxt.stat = GPA_ST_IDLE;
                    s_nxt.st = A_HOLD;
                end
            end
            A_HOLD: begin
                if (begun) begin
                    s_nxt.started = 1'b1;
                    s_nxt.st = A_BUSY;
                end else if (s_r.win == 2'(GPA_FRAME_WIN)) begin
                    s_nxt.st = A_IDLE;
                end else begin
                    s_nxt.win = s_r.win - 2'(GPA_FRAME_WIN);
                end
            end
            A_BUSY: begin
                // enqueue ends when pipe and frame are off
                if (link.frame_n && link.pipe_n) begin
                    s_nxt.st = A_IDLE;
                end
            end
            default: s_nxt.st = A_IDLE;
        endcase
        s_nxt.open = (s_nxt.st == A_GRANT) || (s_nxt.st == A_HOLD);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_r <= '{st: A_IDLE, gnt_n: 1'b1, stat: GPA_ST_IDLE, win: 2'h0,
                     open: 1'b0, started: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.gnt_n = s_r.gnt_n;
    assign link.st = s_r.stat;
    assign window_open = s_r.open;
    assign started = s_r.started;
endmodule : gpa_arbiter

/* rtl/gpa_link_if.sv */
// Interface joining the arbiter and the graphics master; all strobes active low, st is a 3-bit status
interface gpa_link_if;
    logic req_n;
    logic gnt_n;
    logic [2:0] st;
    logic pipe_n;
    logic frame_n;

    modport arbiter (
        input req_n,
        input pipe_n,
        input frame_n,
        output gnt_n,
        output st
    );

    modport master (
        output req_n,
        output pipe_n,
        output frame_n,
        input gnt_n,
        input st
    );
endinterface : gpa_link_if

/* rtl/gpa_master.sv */
// Graphics master end: requests, then starts pipe or frame cycles
module gpa_master (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Link
    gpa_link_if.master link,
    // User side
    input wire logic start_valid,
    input wire gpa_pkg::gpa_kind_type start_kind,
    input wire logic [gpa_pkg::GPA_REQ_W-1:0] start_count,
    input wire logic more_pending,
    input wire logic sba_enable,
    output logic start_ready,
    output logic busy,
    output logic forfeit
);
    import gpa_pkg::*;

    typedef enum logic [1:0] {M_IDLE, M_WAIT, M_PIPE, M_LAST} gpa_mstate_type;
    typedef struct packed {
        gpa_mstate_type st;
        gpa_kind_type kind;
        logic [GPA_REQ_W-1:0] left;
        logic more;
        logic req_n;
        logic pipe_n;
        logic frame_n;
        logic ready;
        logic busy;
        logic forfeit;
        logic gap;
        logic armed;
        logic used;
    } gpa_mreg_type;

    gpa_mreg_type s_r, s_nxt;
    logic granted;

    assign granted = !link.gnt_n && link.st == GPA_ST_START;

    always_comb begin
        s_nxt = s_r;
        s_nxt.forfeit = 1'b0;
        s_nxt.frame_n = 1'b1;
        s_nxt.gap = 1'b0;
        unique case (s_r.st)
            M_IDLE: begin
                s_nxt.ready = !s_r.gap;
                if (start_valid && s_r.ready && start_kind != GPA_KIND_NONE
                        && !(start_kind == GPA_KIND_PIPE && sba_enable)) begin
                    s_nxt.st = M_WAIT;
                    s_nxt.kind = start_kind;
                    s_nxt.left = (start_count == GPA_ZERO) ? GPA_ONE : start_count;
                    s_nxt.more = more_pending;
                    s_nxt.req_n = 1'b0;
                    s_nxt.ready = 1'b0;
                    s_nxt.busy = 1'b1;
                end
            end
            M_WAIT: begin
                if (granted && s_r.kind == GPA_KIND_PCI) begin
                    s_nxt.frame_n = 1'b0;
                    s_nxt.req_n = s_r.more ? 1'b0 : 1'b1;
                    s_nxt.st = M_IDLE;
                    s_nxt.busy = 1'b0;
                end else if (granted) begin
                    s_nxt.pipe_n = 1'b0;
                    s_nxt.req_n = (s_r.left == GPA_ONE);
                    s_nxt.left = s_r.left - GPA_ONE;
                    s_nxt.st = (s_r.left == GPA_ONE) ? M_LAST : M_PIPE;
                end
            end
            M_PIPE: begin
                s_nxt.left = s_r.left - GPA_ONE;
                // request drops one clock before pipe
                if (s_r.left == GPA_ONE) begin
                    s_nxt.req_n = 1'b1;
                    s_nxt.st = M_LAST;
                end
            end
            M_LAST: begin
                // pipe drops after the last request
                s_nxt.pipe_n = 1'b1;
                s_nxt.st = M_IDLE;
                s_nxt.busy = 1'b0;
                s_nxt.gap = 1'b1;
            end
            default: s_nxt.st = M_IDLE;
        endcase
        // unused grant forfeits start
        // Only a grant met while idle can lapse; a waiting master starts at once
        s_nxt.used = granted && (s_r.used || s_r.st == M_WAIT);
        s_nxt.armed = granted && !s_nxt.used;
        s_nxt.forfeit = s_r.armed && !granted;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_r <= '{st: M_IDLE, kind: GPA_KIND_NONE, left: '0, more: 1'b0,
                     req_n: 1'b1, pipe_n: 1'b1, frame_n: 1'b1, ready: 1'b0,
                     busy: 1'b0, forfeit: 1'b0, gap: 1'b0, armed: 1'b0, used: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.req_n = s_r.req_n;
    assign link.pipe_n = s_r.pipe_n;
    assign link.frame_n = s_r.frame_n;
    assign start_ready = s_r.ready;
    assign busy = s_r.busy;
    assign forfeit = s_r.forfeit;
endmodule : gpa_master

/* rtl/gpa_pkg.sv */
// Package for the graphics port request/grant arbitration ends
// Summary of operation
// - Master raises request when needing the bus
// - Request held until one clock before pipe ends
// - Pipe without request marks last; pipe drops next
// - No request reassertion to extend an enqueue
// - Pack many requests into one enqueue
// - Request dropped with frame if nothing pending
// - Sideband-enabled master never uses pipe
// - Arbiter drives status, valid only with grant
// - Pipe within two clocks of full grant
// - Frame starts on the full-grant clock
// - Frame only while granted and bus idle
// - Late frame allowed while grant stays
// - Arbiter may withdraw grant any clock
// - No new grant until start window passes
// - Each grant clock extends the windows
package gpa_pkg;
    localparam logic [2:0] GPA_ST_START = 3'h7;
    localparam logic [2:0] GPA_ST_IDLE = 3'h0;
    localparam int GPA_PIPE_WIN = 2;
    localparam int GPA_FRAME_WIN = 1;
    localparam int GPA_REQ_W = 8;
    localparam logic [7:0] GPA_ONE = 8'h01;
    localparam logic [7:0] GPA_ZERO = 8'h00;

    typedef enum logic [1:0] {
        GPA_KIND_NONE,
        GPA_KIND_PCI,
        GPA_KIND_PIPE
    } gpa_kind_type;
endpackage : gpa_pkg

/* sim/gpa_link_sva.sv */
// Checker watching the request/grant link between both ends
module gpa_link_sva
    import gpa_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Link
    input wire logic req_n,
    input wire logic gnt_n,
    input wire logic [2:0] st,
    input wire logic pipe_n,
    input wire logic frame_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_st_with_grant: assert property (st == (gnt_n ? GPA_ST_IDLE : GPA_ST_START))
        else $error("status out of step with grant");
    a_grant_needs_req: assert property ($fell(gnt_n) |-> !$past(req_n))
        else $error("grant without request");
    a_start_after_grant: assert property ($fell(gnt_n) |=> !pipe_n || !frame_n || !gnt_n)
        else $error("no start the clock after grant");
    a_frame_needs_grant: assert property ($fell(frame_n) |-> !$past(gnt_n))
        else $error("frame without grant");
    a_pipe_in_window: assert property ($fell(pipe_n) |-> !$past(gnt_n) || !$past(gnt_n, 2))
        else $error("pipe outside its window");
    a_req_holds_pipe: assert property (!pipe_n && !req_n |=> !pipe_n)
        else $error("pipe ended while request held");
    a_last_pipe_drops: assert property (!pipe_n && req_n |=> pipe_n)
        else $error("pipe held after last request");
    a_req_stays_off: assert property (!pipe_n && req_n |=> req_n)
        else $error("request reasserted inside enqueue");
    a_regrant_gap: assert property ($rose(gnt_n) && pipe_n && frame_n
        && $past(pipe_n) && $past(frame_n) |=> gnt_n)
        else $error("grant renewed inside start window");
    c_frame: cover property ($fell(frame_n));
    c_long_pipe: cover property (!pipe_n && !req_n);
    c_last_pipe: cover property (!pipe_n && req_n);
    c_grant_lost: cover property ($rose(gnt_n) && pipe_n && frame_n && $past(pipe_n)
        && $past(frame_n));
endmodule : gpa_link_sva

/* sim/test_graphics_port_req_gnt_arbitration.sv */
// Testbench joining master and arbiter across the link
module test_graphics_port_req_gnt_arbitration import gpa_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 0;
    logic srst = 1, start_valid = 0, more_pending = 0, sba_enable = 0;
    logic grant_en = 1, withdraw = 0, start_ready;
    logic busy, forfeit, window_open, started;
    gpa_kind_type start_kind = GPA_KIND_NONE;
    logic [7:0] start_count = 8'h00;
    int num_errors = 0, cmp_count = 0;
    gpa_link_if link ();
    gpa_master u_gpa_master (.ref_clk(ref_clk), .srst(srst), .link(link),
        .start_valid(start_valid), .start_kind(start_kind), .start_count(start_count),
        .more_pending(more_pending), .sba_enable(sba_enable), .start_ready(start_ready),
        .busy(busy), .forfeit(forfeit));
    gpa_arbiter u_gpa_arbiter (.ref_clk(ref_clk), .srst(srst), .link(link),
        .grant_en(grant_en), .withdraw(withdraw), .window_open(window_open),
        .started(started));
    gpa_link_sva u_gpa_link_sva (.ref_clk(ref_clk), .srst(srst), .req_n(link.req_n),
        .gnt_n(link.gnt_n), .st(link.st), .pipe_n(link.pipe_n), .frame_n(link.frame_n));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge ref_clk);
        #2;
    endtask : tick
    task automatic do_start(input gpa_kind_type k, input logic [7:0] c);
        int n;
        n = 0;
        start_valid = 1'b1;
        start_kind = k;
        start_count = c;
        while (start_ready !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        tick();
        start_valid = 1'b0;
    endtask : do_start
    task automatic wait_start();
        int n;
        n = 0;
        while (link.pipe_n !== 1'b0 && link.frame_n !== 1'b0 && n < 20) begin
            tick();
            n++;
        end
    endtask : wait_start
    task automatic t_pipe(input logic [7:0] c);
        do_start(GPA_KIND_PIPE, c);
        wait_start();
        for (int i = 0; i < c; i++) begin
            chk(link.pipe_n, 8'h00);
            chk(link.req_n, 8'(i == c - 1));
            chk(busy, 8'h01);
            tick();
        end
        chk(link.pipe_n, 8'h01);
        chk(busy, 8'h00);
        $display("enqueue of %0d done", c);
    endtask : t_pipe
    task automatic t_pci();
        do_start(GPA_KIND_PCI, 8'h01);
        wait_start();
        chk(link.frame_n, 8'h00);
        chk(link.req_n, 8'h01);
        chk(window_open, 8'h01);
        tick();
        chk(link.frame_n, 8'h01);
        chk(started, 8'h01);
        chk(window_open, 8'h00);
        $display("frame start done");
    endtask : t_pci
    task automatic t_sba();
        sba_enable = 1'b1;
        start_valid = 1'b1;
        start_kind = GPA_KIND_PIPE;
        repeat (8) tick();
        chk(link.pipe_n, 8'h01);
        chk(start_ready, 8'h01);
        start_valid = 1'b0;
        sba_enable = 1'b0;
        tick();
        $display("sideband refusal done");
    endtask : t_sba
    task automatic t_withdraw();
        withdraw = 1'b1;
        do_start(GPA_KIND_PCI, 8'h01);
        repeat (4) tick();
        chk(link.gnt_n, 8'h01);
        withdraw = 1'b0;
        wait_start();
        chk(link.frame_n, 8'h00);
        tick();
        $display("withdrawn grant done");
    endtask : t_withdraw
    task automatic t_regrant();
        more_pending = 1'b1;
        do_start(GPA_KIND_PCI, 8'h01);
        more_pending = 1'b0;
        wait_start();
        chk(link.req_n, 8'h00);
        repeat (4) tick();
        chk(link.gnt_n, 8'h00);
        withdraw = 1'b1;
        repeat (2) tick();
        chk(forfeit, 8'h01);
        chk(window_open, 8'h01);
        withdraw = 1'b0;
        tick();
        chk(link.gnt_n, 8'h01);
        tick();
        chk(link.gnt_n, 8'h00);
        do_start(GPA_KIND_PCI, 8'h01);
        wait_start();
        chk(link.frame_n, 8'h00);
        tick();
        chk(forfeit, 8'h00);
        $display("forfeited grant done");
    endtask : t_regrant
    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #50us;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #2;
        srst = 1'b0;
        tick();
        t_pipe(8'h01);
        t_pipe(8'h03);
        t_pipe(8'h02);
        t_pci();
        t_sba();
        t_withdraw();
        t_regrant();
        complete_run();
    end
endmodule : test_graphics_port_req_gnt_arbitration
